//--- inc/fcr_defines.vh
`ifndef FCR_DEFINES_VH
`define FCR_DEFINES_VH

// register indices as printed; byte address is four times the index
`define FCR_IDX_TAP_A_EIGHTH 12'h427
`define FCR_IDX_TAP_A_NINTH 12'h429
`define FCR_IDX_TAP_B_FIRST 12'h448
`define FCR_IDX_TAP_B_SECOND 12'h44A
`define FCR_IDX_TAP_B_THIRD 12'h44C
// mode register, own index
`define FCR_IDX_MODE 12'h460

`define FCR_ADDR_W 14
`define FCR_REG_W 16
`define FCR_COEF_W 12
`define FCR_COEF_MSB 11
`define FCR_RSVD_LSB 12
`define FCR_RESET_VAL 16'h0000
`define FCR_NUM_TAPS 5

`define FCR_RESP_OKAY 2'h0
`define FCR_RESP_SLVERR 2'h2

`endif

//--- src/fcr_regs.v
`include "fcr_defines.vh"

module fcr_regs (
    input wire aclk, // clock, 40 MHz
    input wire aresetn, // synchronous reset, active low
    input wire [`FCR_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire [2:0] s_axi_awprot, // unused
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [`FCR_ADDR_W-1:0] s_axi_araddr, // read address
    input wire [2:0] s_axi_arprot, // unused
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read valid
    input wire s_axi_rready, // read ready
    output reg single_mode, // 1: single-channel, 0: dual-channel
    output reg [`FCR_COEF_W-1:0] eq_a_tap8, // channel A / combined eighth tap
    output reg [`FCR_COEF_W-1:0] eq_a_tap9, // channel A / combined ninth tap
    output reg [`FCR_COEF_W-1:0] eq_b_tap1, // channel B first tap
    output reg [`FCR_COEF_W-1:0] eq_b_tap2, // channel B second tap
    output reg [`FCR_COEF_W-1:0] eq_b_tap3 // channel B third tap
);

    localparam [`FCR_ADDR_W-3:0] IDX_MODE = `FCR_IDX_MODE;
    localparam [(`FCR_NUM_TAPS*12)-1:0] TAP_IDX = {
        `FCR_IDX_TAP_B_THIRD, `FCR_IDX_TAP_B_SECOND, `FCR_IDX_TAP_B_FIRST,
        `FCR_IDX_TAP_A_NINTH, `FCR_IDX_TAP_A_EIGHTH};

    // tap storage, one word per coefficient register
    reg [`FCR_REG_W-1:0] tap_q [0:`FCR_NUM_TAPS-1];

    // mode bit
    reg mode_q;
    reg mode_d;

    // captured write request
    reg [`FCR_ADDR_W-1:0] awaddr_q;
    reg [`FCR_ADDR_W-1:0] awaddr_d;
    reg [31:0] wdata_q;
    reg [31:0] wdata_d;
    reg [3:0] wstrb_q;
    reg [3:0] wstrb_d;
    reg aw_have_q;
    reg aw_have_d;
    reg w_have_q;
    reg w_have_d;

    // next values of the bus outputs
    reg awready_d;
    reg wready_d;
    reg bvalid_d;
    reg [1:0] bresp_d;
    reg arready_d;
    reg rvalid_d;
    reg [31:0] rdata_d;
    reg [1:0] rresp_d;

    // read select
    reg [`FCR_REG_W-1:0] rsel_val;
    reg rsel_hit;

    // next values of the filter-side outputs
    reg single_mode_d;
    reg [`FCR_COEF_W-1:0] a_tap8_d;
    reg [`FCR_COEF_W-1:0] a_tap9_d;
    reg [`FCR_COEF_W-1:0] b_tap1_d;
    reg [`FCR_COEF_W-1:0] b_tap2_d;
    reg [`FCR_COEF_W-1:0] b_tap3_d;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire b_take = s_axi_bvalid && s_axi_bready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire r_take = s_axi_rvalid && s_axi_rready;
    wire [`FCR_ADDR_W-3:0] widx = awaddr_q[`FCR_ADDR_W-1:2];
    wire [`FCR_ADDR_W-3:0] ridx = s_axi_araddr[`FCR_ADDR_W-1:2];
    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire [`FCR_NUM_TAPS-1:0] whit;
    wire [`FCR_NUM_TAPS-1:0] rhit;
    wire whit_mode = (widx == IDX_MODE);
    wire rhit_mode = (ridx == IDX_MODE);
    wire wmapped = (|whit) || whit_mode;

    genvar g;
    generate
        for (g = 0; g < `FCR_NUM_TAPS; g = g + 1) begin : g_tap
            reg [`FCR_REG_W-1:0] tap_d;
            assign whit[g] = (widx == TAP_IDX[g*12 +: 12]);
            assign rhit[g] = (ridx == TAP_IDX[g*12 +: 12]);
            // lanes 3:2 carry nothing here; reserved bits store but never reach the filter
            always @* begin
                tap_d = tap_q[g];
                if (do_write && whit[g]) begin
                    if (wstrb_q[0]) begin
                        tap_d[7:0] = wdata_q[7:0];
                    end
                    if (wstrb_q[1]) begin
                        tap_d[15:8] = wdata_q[15:8];
                    end
                end
            end
            always @(posedge aclk) begin
                if (!aresetn) begin
                    tap_q[g] <= `FCR_RESET_VAL;
                end else begin
                    tap_q[g] <= tap_d;
                end
            end
        end
    endgenerate

    // address half of a write, held until its response is taken
    always @* begin
        awready_d = !aw_have_q && !s_axi_awready && s_axi_awvalid;
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        if (aw_take) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (b_take) begin
            aw_have_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have_q <= 1'b0;
            awaddr_q <= {`FCR_ADDR_W{1'b0}};
        end else begin
            s_axi_awready <= awready_d;
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
        end
    end

    // data half of a write, may arrive before or after the address
    always @* begin
        wready_d = !w_have_q && !s_axi_wready && s_axi_wvalid;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        if (w_take) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (b_take) begin
            w_have_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            s_axi_wready <= wready_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
        end
    end

    // response: one write at a time, so a held response blocks the next
    always @* begin
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        if (do_write) begin
            bvalid_d = 1'b1;
            bresp_d = wmapped ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
        end else if (b_take) begin
            bvalid_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FCR_RESP_OKAY;
        end else begin
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
        end
    end

    always @* begin
        mode_d = mode_q;
        if (do_write && whit_mode && wstrb_q[0]) begin
            mode_d = wdata_q[0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
        end
    end

    // live address is safe: the master holds araddr until the accept edge
    always @* begin
        rsel_val = {`FCR_REG_W{1'b0}};
        rsel_hit = 1'b1;
        case (rhit)
            5'h01: begin
                rsel_val = tap_q[0];
            end
            5'h02: begin
                rsel_val = tap_q[1];
            end
            5'h04: begin
                rsel_val = tap_q[2];
            end
            5'h08: begin
                rsel_val = tap_q[3];
            end
            5'h10: begin
                rsel_val = tap_q[4];
            end
            default: begin
                rsel_hit = 1'b0;
            end
        endcase
        if (rhit_mode) begin
            rsel_val = {15'h0000, mode_q};
            rsel_hit = 1'b1;
        end
    end

    // read: accept one cycle, data the next; unmapped reads return zero
    always @* begin
        arready_d = !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rdata_d = {16'h0000, rsel_val};
            rresp_d = rsel_hit ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
        end else if (r_take) begin
            rvalid_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FCR_RESP_OKAY;
        end else begin
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
        end
    end

    // same registers serve both modes; centre 18-bit tap lives elsewhere
    always @* begin
        single_mode_d = mode_q;
        a_tap8_d = tap_q[0][`FCR_COEF_MSB:0];
        a_tap9_d = tap_q[1][`FCR_COEF_MSB:0];
        b_tap1_d = tap_q[2][`FCR_COEF_MSB:0];
        b_tap2_d = tap_q[3][`FCR_COEF_MSB:0];
        b_tap3_d = tap_q[4][`FCR_COEF_MSB:0];
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            single_mode <= 1'b0;
            eq_a_tap8 <= {`FCR_COEF_W{1'b0}};
            eq_a_tap9 <= {`FCR_COEF_W{1'b0}};
            eq_b_tap1 <= {`FCR_COEF_W{1'b0}};
            eq_b_tap2 <= {`FCR_COEF_W{1'b0}};
            eq_b_tap3 <= {`FCR_COEF_W{1'b0}};
        end else begin
            single_mode <= single_mode_d;
            eq_a_tap8 <= a_tap8_d;
            eq_a_tap9 <= a_tap9_d;
            eq_b_tap1 <= b_tap1_d;
            eq_b_tap2 <= b_tap2_d;
            eq_b_tap3 <= b_tap3_d;
        end
    end

endmodule

//--- dv/fcr_regs_props.sv
module fcr_regs_props (
    input wire aclk, // clock
    input wire aresetn, // sync reset, active low
    input wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire s_axi_rvalid, // read valid
    input wire s_axi_rready, // read ready
    input wire [31:0] s_axi_rdata, // read data
    input wire [11:0] eq_a_tap8, // tap outputs
    input wire [11:0] eq_a_tap9, // tap outputs
    input wire [11:0] eq_b_tap1, // tap outputs
    input wire [11:0] eq_b_tap2, // tap outputs
    input wire [11:0] eq_b_tap3 // tap outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [59:0] taps = {eq_b_tap3, eq_b_tap2, eq_b_tap1, eq_a_tap9, eq_a_tap8};
    default clocking @(posedge aclk); endclocking
    // reset checks must not be switched off by the reset itself
    AST_RST_A8: assert property (!aresetn |=> eq_a_tap8 == 12'h000)
        else $error("tap a8 not cleared");
    AST_RST_A9: assert property (!aresetn |=> eq_a_tap9 == 12'h000)
        else $error("tap a9 not cleared");
    AST_RST_B1: assert property (!aresetn |=> eq_b_tap1 == 12'h000)
        else $error("tap b1 not cleared");
    AST_RST_B2: assert property (!aresetn |=> eq_b_tap2 == 12'h000)
        else $error("tap b2 not cleared");
    AST_RST_B3: assert property (!aresetn |=> eq_b_tap3 == 12'h000)
        else $error("tap b3 not cleared");
    AST_TAP_HOLD: assert property (disable iff (!aresetn)
        $changed(taps) && $past(aresetn) |-> $past(s_axi_bvalid))
        else $error("tap moved without a write");
    AST_RDATA_HI: assert property (disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
    AST_RVALID_ONE: assert property (disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    AST_BVALID_ONE: assert property (disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule
bind fcr_regs fcr_regs_props i_fcr_regs_props (.*);

//--- dv/tb_fcr_regs.sv
`include "fcr_defines.vh"
module tb_fcr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0;
    logic aresetn = 0;
    logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, single_mode;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] eq_a_tap8, eq_a_tap9, eq_b_tap1, eq_b_tap2, eq_b_tap3;
    logic [11:0] idx_t [5] = '{`FCR_IDX_TAP_A_EIGHTH, `FCR_IDX_TAP_A_NINTH,
        `FCR_IDX_TAP_B_FIRST, `FCR_IDX_TAP_B_SECOND, `FCR_IDX_TAP_B_THIRD};
    logic [11:0] exp_t [5] = '{default: 12'h000};
    int bad_count = 0;
    int check_count = 0;
    wire [59:0] tapv = {eq_b_tap3, eq_b_tap2, eq_b_tap1, eq_a_tap9, eq_a_tap8};
    fcr_regs i_fcr_regs (.*);
    initial forever #12.5 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic taps_chk();
        for (int j = 0; j < 5; j++) chk("tap", exp_t[j], tapv[j*12 +: 12]);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk("bresp", er, s_axi_bresp);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge aclk);
    endtask
    task automatic final_report();
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 5; i++) rd(idx_t[i], 0, `FCR_RESP_OKAY);
        taps_chk();
        // negative values with reserved bits set, all taps compared each time
        for (int i = 0; i < 5; i++) begin
            wr(idx_t[i], 32'hFFFF_F800 + i, `FCR_RESP_OKAY);
            exp_t[i] = 12'h800 + i[11:0];
            taps_chk();
            rd(idx_t[i], 32'h0000_F800 + i, `FCR_RESP_OKAY);
        end
        wr(`FCR_IDX_MODE, 32'h1, `FCR_RESP_OKAY);
        chk("mode", 1, single_mode);
        taps_chk();
        wr(12'h428, 32'h0000_0ABC, `FCR_RESP_SLVERR);
        rd(12'h428, 0, `FCR_RESP_SLVERR);
        taps_chk();
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        exp_t = '{default: 12'h000};
        taps_chk();
        chk("mode", 0, single_mode);
        final_report();
    end
    initial begin
        repeat (2000) @(posedge aclk);
        bad_count++;
        final_report();
    end
endmodule
